// ### src/uep_defines.svh
// register offsets, field positions, reset values and limits of the endpoint
// assumes inclusion by bare name from the endpoint and host design files
`ifndef UEP_DEFINES_SVH
`define UEP_DEFINES_SVH

`define UEP_EP4_CSR_OFS 8'h30
`define UEP_EP4_CSR_RST 32'h0000_2001

`define UEP_BIT_IN_TOG_CLR 30
`define UEP_BIT_IN_STALL_SENT 29
`define UEP_BIT_IN_STALL_REQ 28
`define UEP_BIT_IN_FLUSH 27
`define UEP_BIT_IN_UNDERRUN 26
`define UEP_BIT_IN_OCC_HI 25
`define UEP_BIT_IN_READY 24
`define UEP_BIT_OUT_TOG_CLR 23
`define UEP_BIT_OUT_STALL_SENT 22
`define UEP_BIT_ISO 14
`define UEP_BIT_MODE 13
`define UEP_CODE_MSB 3

`define UEP_MODE_RST 1'b1
`define UEP_CODE_RST 4'h1
`define UEP_PACKET_SIZE_CODE_UNIT 8'h08
`define UEP_PACKET_SIZE_CODE_LIMIT 8'h10
`define UEP_FIFO_BYTES 8'h20

`define UEP_OCC_EMPTY 2'h0
`define UEP_OCC_ONE 2'h2
`define UEP_OCC_FULL 2'h3

`endif

// ### src/uep_pkg.sv
// types shared by both ends of the endpoint link
// assumes the defines header is on the include path
package uep_pkg;
    typedef enum logic [2:0] {
        UEP_HS_NAK,
        UEP_HS_ACK,
        UEP_HS_STALL,
        UEP_HS_DATA,
        UEP_HS_ZLP
    } uep_hs_t;
endpackage : uep_pkg

// ### src/uep_link_if.sv
// token and handshake link between the host end and the endpoint end
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface uep_link_if;
    import uep_pkg::*;
    logic token_valid;
    logic token_in;
    logic [7:0] out_len;
    logic out_pid;
    logic done_valid;
    logic done_ok;
    logic hs_valid;
    uep_hs_t hs_code;
    logic [7:0] hs_len;
    logic hs_pid;

    modport dev (
        input token_valid,
        input token_in,
        input out_len,
        input out_pid,
        input done_valid,
        input done_ok,
        output hs_valid,
        output hs_code,
        output hs_len,
        output hs_pid
    );

    modport host (
        output token_valid,
        output token_in,
        output out_len,
        output out_pid,
        output done_valid,
        output done_ok,
        input hs_valid,
        input hs_code,
        input hs_len,
        input hs_pid
    );
endinterface : uep_link_if
`default_nettype wire

// ### src/uep_endpoint.sv
// endpoint control/status register and in/out token answering logic
// assumes a host end on the same clock and a cpu on the plain register port
// Operation
// - csr at 0x30, resets to 0x2001
// - writing one clears in data toggle
// - in stall-sent flag set, cleared by read
// - sending in stall clears packet ready
// - stall request makes in tokens stall
// - flush drops one packet, self-clears, interrupts cpu
// - flush waits for running transaction
// - flush removes only oldest of two packets
// - iso in token unready sets underrun
// - underrun sends empty packet, drops next load
// - occupancy reports 00, 10 or 11
// - ready cleared on host success of the last queued packet, interrupt raised
// - ready blocks cpu fifo writes
// - stall request blocks setting ready
// - writing one resets out toggle to data0
// - out stall-sent flag set, cleared by read
// - in and out controls act per direction
// - direction bit: 0 out, 1 in, resets in
// - oversize out data answered with stall
// - packet size at most 16 bytes
`include "uep_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module uep_endpoint
    import uep_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [7:0] FIFO_BYTES = `UEP_FIFO_BYTES
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    uep_link_if.dev link,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic fifo_wr_in,
    output logic fifo_wr_block_out,
    output logic in_packet_ready_out,
    output logic cpu_irq_out
);

    function automatic logic [7:0] packet_size_code_bytes(input logic [3:0] code);
        logic [7:0] size;
        size = {1'b0, code, 3'b000};
        if (size < `UEP_PACKET_SIZE_CODE_UNIT)
        begin
            size = `UEP_PACKET_SIZE_CODE_UNIT;
        end
        if (size > `UEP_PACKET_SIZE_CODE_LIMIT)
        begin
            size = `UEP_PACKET_SIZE_CODE_LIMIT;
        end
        return size;
    endfunction : packet_size_code_bytes

    function automatic logic [1:0] occ_code(input logic [1:0] cnt, input logic [7:0] len);
        logic [1:0] occ;
        occ = `UEP_OCC_FULL;
        if (cnt == 2'd0)
        begin
            occ = `UEP_OCC_EMPTY;
        end
        else if (cnt == 2'd1 && len <= (FIFO_BYTES >> 1))
        begin
            occ = `UEP_OCC_ONE;
        end
        return occ;
    endfunction : occ_code

    logic mode;
    logic iso;
    logic [3:0] code;
    logic stall_req;
    logic flush_req;
    logic in_stall_sent;
    logic underrun;
    logic out_stall_sent;
    logic in_toggle;
    logic out_toggle;
    logic busy;
    logic discard_next;
    logic [1:0] pkt_cnt;
    logic [7:0] pkt_len [0:1];
    logic [7:0] load_len;
    logic [1:0] next_cnt;

    logic wr_hit;
    logic rd_hit;
    logic in_tok;
    logic out_tok;
    logic stall_in;
    logic data_in;
    logic zlp_in;
    logic out_big;
    logic out_ok;
    logic done_ok_ev;
    logic flush_go;
    logic commit;
    logic push;
    logic pop;
    logic push_idx;

    assign wr_hit = reg_wr_in && reg_addr_in == ADDR_W'(`UEP_EP4_CSR_OFS);
    assign rd_hit = reg_rd_in && reg_addr_in == ADDR_W'(`UEP_EP4_CSR_OFS);
    // tokens for the other direction are simply refused
    assign in_tok = link.token_valid && link.token_in && mode;
    assign out_tok = link.token_valid && !link.token_in && !mode;
    assign stall_in = in_tok && stall_req;
    assign data_in = in_tok && !stall_req && in_packet_ready_out;
    assign zlp_in = in_tok && !stall_req && !in_packet_ready_out && iso;
    assign out_big = out_tok && link.out_len > packet_size_code_bytes(code);
    assign out_ok = out_tok && !out_big;
    assign done_ok_ev = link.done_valid && link.done_ok && busy;
    // a flush never cuts into a packet the host is still taking
    assign flush_go = flush_req && mode && !busy && !link.token_valid;
    assign commit = wr_hit && reg_wdata_in[`UEP_BIT_IN_READY] && mode && !stall_req
        && pkt_cnt != 2'd2;
    assign push = commit && !discard_next;
    assign pop = done_ok_ev || (flush_go && pkt_cnt != 2'd0);
    assign push_idx = (pkt_cnt == 2'd2 || (pkt_cnt == 2'd1 && !pop));
    assign next_cnt = stall_in ? 2'd0 : 2'(pkt_cnt + {1'b0, push} - {1'b0, pop});

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mode <= `UEP_MODE_RST;
            iso <= 1'b0;
            code <= `UEP_CODE_RST;
        end
        else if (wr_hit)
        begin
            mode <= reg_wdata_in[`UEP_BIT_MODE];
            iso <= reg_wdata_in[`UEP_BIT_ISO];
            code <= reg_wdata_in[`UEP_CODE_MSB:0];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            stall_req <= 1'b0;
        end
        else if (wr_hit && mode)
        begin
            stall_req <= reg_wdata_in[`UEP_BIT_IN_STALL_REQ];
        end
    end

    // zero writes leave a pending flush alone
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            flush_req <= 1'b0;
        end
        else if (wr_hit && mode && reg_wdata_in[`UEP_BIT_IN_FLUSH])
        begin
            flush_req <= 1'b1;
        end
        else if (flush_go)
        begin
            flush_req <= 1'b0;
        end
    end

    // hardware set wins over the clearing read
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            in_stall_sent <= 1'b0;
            underrun <= 1'b0;
            out_stall_sent <= 1'b0;
        end
        else
        begin
            in_stall_sent <= stall_in || (in_stall_sent && !rd_hit);
            underrun <= zlp_in || (underrun && !rd_hit);
            out_stall_sent <= out_big || (out_stall_sent && !rd_hit);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            in_toggle <= 1'b0;
        end
        else if (wr_hit && mode && reg_wdata_in[`UEP_BIT_IN_TOG_CLR])
        begin
            in_toggle <= 1'b0;
        end
        else if (done_ok_ev)
        begin
            in_toggle <= !in_toggle;
        end
    end

    // a repeated data pid is acked but not counted, so retries stay in step
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            out_toggle <= 1'b0;
        end
        else if (wr_hit && !mode && reg_wdata_in[`UEP_BIT_OUT_TOG_CLR])
        begin
            out_toggle <= 1'b0;
        end
        else if (out_ok && link.out_pid == out_toggle)
        begin
            out_toggle <= !out_toggle;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            busy <= 1'b0;
        end
        else if (data_in)
        begin
            busy <= 1'b1;
        end
        else if (link.done_valid)
        begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            discard_next <= 1'b0;
        end
        else if (zlp_in)
        begin
            discard_next <= 1'b1;
        end
        else if (commit)
        begin
            discard_next <= 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pkt_cnt <= 2'd0;
            pkt_len[0] <= 8'h00;
            pkt_len[1] <= 8'h00;
        end
        else
        begin
            pkt_cnt <= next_cnt;
            if (pop)
            begin
                pkt_len[0] <= pkt_len[1];
            end
            if (push)
            begin
                pkt_len[push_idx] <= load_len;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            load_len <= 8'h00;
        end
        else if (commit || (flush_go && pkt_cnt == 2'd0))
        begin
            load_len <= 8'h00;
        end
        else if (fifo_wr_in && mode && !in_packet_ready_out && load_len < FIFO_BYTES)
        begin
            load_len <= 8'(load_len + 8'h01);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            in_packet_ready_out <= 1'b0;
            fifo_wr_block_out <= 1'b0;
            cpu_irq_out <= 1'b0;
        end
        else
        begin
            in_packet_ready_out <= next_cnt != 2'd0;
            fifo_wr_block_out <= next_cnt != 2'd0;
            cpu_irq_out <= done_ok_ev || flush_go;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            link.hs_valid <= 1'b0;
            link.hs_code <= UEP_HS_NAK;
            link.hs_len <= 8'h00;
            link.hs_pid <= 1'b0;
        end
        else
        begin
            link.hs_valid <= link.token_valid;
            link.hs_len <= data_in ? pkt_len[0] : 8'h00;
            link.hs_pid <= link.token_in ? in_toggle : out_toggle;
            if (stall_in || out_big)
            begin
                link.hs_code <= UEP_HS_STALL;
            end
            else if (data_in)
            begin
                link.hs_code <= UEP_HS_DATA;
            end
            else if (zlp_in)
            begin
                link.hs_code <= UEP_HS_ZLP;
            end
            else if (out_ok)
            begin
                link.hs_code <= UEP_HS_ACK;
            end
            else
            begin
                link.hs_code <= UEP_HS_NAK;
            end
        end
    end

    // write-only and reserved bits read as zero
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
        else if (rd_hit)
        begin
            reg_rdata_out <= {2'b00, in_stall_sent, stall_req, flush_req, underrun,
                occ_code(pkt_cnt, pkt_len[0]), 1'b0, out_stall_sent, 7'h00, iso, mode,
                9'h000, code};
        end
        else
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule : uep_endpoint
`default_nettype wire

// ### src/uep_host.sv
// host end: issues in and out tokens, tracks data toggles, returns results
// assumes the endpoint end answers one cycle after each token
`include "uep_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module uep_host
    import uep_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    uep_link_if.host link,
    input wire logic in_token_req_in,
    input wire logic out_token_req_in,
    input wire logic [7:0] out_len_in,
    input wire logic accept_in,
    input wire logic toggle_reset_in,
    output logic busy_out,
    output logic result_valid_out,
    output uep_hs_t result_code_out,
    output logic [7:0] result_len_out,
    output logic result_pid_out
);

    typedef enum logic {UEP_H_IDLE, UEP_H_WAIT} uep_hstate_t;

    uep_hstate_t state;
    logic in_expect;
    logic out_send;
    logic take_data;

    assign take_data = link.hs_valid && link.hs_code == UEP_HS_DATA;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state <= UEP_H_IDLE;
            busy_out <= 1'b0;
            link.token_valid <= 1'b0;
            link.token_in <= 1'b0;
            link.out_len <= 8'h00;
            link.out_pid <= 1'b0;
        end
        else
        begin
            link.token_valid <= 1'b0;
            unique case (state)
                UEP_H_IDLE:
                begin
                    if (in_token_req_in || out_token_req_in)
                    begin
                        link.token_valid <= 1'b1;
                        link.token_in <= in_token_req_in;
                        link.out_len <= out_len_in;
                        link.out_pid <= out_send;
                        busy_out <= 1'b1;
                        state <= UEP_H_WAIT;
                    end
                end
                UEP_H_WAIT:
                begin
                    if (link.hs_valid)
                    begin
                        busy_out <= 1'b0;
                        state <= UEP_H_IDLE;
                    end
                end
            endcase
        end
    end

    // only an accepted, expected in packet counts as received
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            link.done_valid <= 1'b0;
            link.done_ok <= 1'b0;
        end
        else
        begin
            link.done_valid <= take_data;
            link.done_ok <= take_data && accept_in && link.hs_pid == in_expect;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in || toggle_reset_in)
        begin
            in_expect <= 1'b0;
            out_send <= 1'b0;
        end
        else
        begin
            if (take_data && accept_in && link.hs_pid == in_expect)
            begin
                in_expect <= !in_expect;
            end
            if (link.hs_valid && link.hs_code == UEP_HS_ACK && !link.token_in)
            begin
                out_send <= !out_send;
            end
        end
    end

    // stall is reported upward; the host keeps retrying only on request
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            result_valid_out <= 1'b0;
            result_code_out <= UEP_HS_NAK;
            result_len_out <= 8'h00;
            result_pid_out <= 1'b0;
        end
        else
        begin
            result_valid_out <= link.hs_valid;
            if (link.hs_valid)
            begin
                result_code_out <= link.hs_code;
                result_len_out <= link.hs_len;
                result_pid_out <= link.hs_pid;
            end
        end
    end

endmodule : uep_host
`default_nettype wire

// ### tb/uep_link_checker.sv
// concurrent checks on the token/handshake link between the two ends
// assumes instantiation in tb beside the link interface, one clock domain
`timescale 1ns/10ps
`default_nettype none
module uep_link_checker
    import uep_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic token_valid,
    input wire logic token_in,
    input wire logic [7:0] out_len,
    input wire logic out_pid,
    input wire logic done_valid,
    input wire logic done_ok,
    input wire logic hs_valid,
    input wire uep_hs_t hs_code,
    input wire logic [7:0] hs_len,
    input wire logic hs_pid
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_in_token;
        token_valid && token_in;
    endsequence
    sequence s_out_token;
        token_valid && !token_in;
    endsequence
    sequence s_data_hs;
        hs_valid && hs_code == UEP_HS_DATA;
    endsequence

    AST_HS_AFTER_TOKEN:
        assert property (token_valid |=> hs_valid && !token_valid) else $error("no handshake");
    AST_HS_CAUSE:
        assert property (hs_valid |-> $past(token_valid)) else $error("stray handshake");
    AST_OVERSIZE_STALL:
        assert property ((token_valid && !token_in && out_len > 8'h10)
            |=> hs_code inside {UEP_HS_STALL, UEP_HS_NAK}) else $error("oversize not stalled");
    AST_SMALL_NO_STALL:
        assert property ((token_valid && !token_in && out_len <= 8'h08)
            |=> hs_code != UEP_HS_STALL) else $error("small out stalled");
    AST_OUT_ANSWERS:
        assert property (s_out_token |=> hs_code inside {UEP_HS_ACK, UEP_HS_STALL, UEP_HS_NAK})
            else $error("bad out answer");
    AST_IN_ANSWERS:
        assert property (s_in_token |=> hs_code != UEP_HS_ACK) else $error("bad in answer");
    AST_ZLP_EMPTY:
        assert property (hs_valid && hs_code == UEP_HS_ZLP |-> hs_len == 8'h00)
            else $error("zlp with data");
    AST_STALL_EMPTY:
        assert property (hs_valid && hs_code == UEP_HS_STALL |-> hs_len == 8'h00)
            else $error("stall with data");
    AST_DONE_FOLLOWS_DATA:
        assert property (s_in_token ##1 s_data_hs |=> done_valid) else $error("no done");
    AST_DONE_CAUSE:
        assert property (done_valid |-> $past(hs_valid && hs_code == UEP_HS_DATA))
            else $error("stray done");
endmodule : uep_link_checker
`default_nettype wire

// ### tb/tb.sv
// self-checking bench: host end and endpoint end joined by the link
// assumes design files and the link checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb
    import uep_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, fifo_wr_in = 1'b0;
    logic in_token_req_in = 1'b0, out_token_req_in = 1'b0;
    logic [7:0] out_len_in = 8'h00;
    logic accept_in = 1'b1, toggle_reset_in = 1'b0;
    logic [31:0] reg_rdata_out, rdv;
    logic fifo_wr_block_out, in_packet_ready_out, cpu_irq_out, busy_out, result_valid_out;
    uep_hs_t result_code_out;
    logic [7:0] result_len_out, n;
    logic result_pid_out, in_tog, out_tog, stl;
    int err_total = 0, total_checks = 0, irq_total = 0, irq0;
    integer seed = 32'hC140;

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (cpu_irq_out === 1'b1) irq_total++;

    uep_link_if uep_link_if_i ();
    uep_endpoint uep_endpoint_i (.clk_in(clk_in), .reset_in(reset_in), .link(uep_link_if_i),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fifo_wr_in(fifo_wr_in),
        .fifo_wr_block_out(fifo_wr_block_out), .in_packet_ready_out(in_packet_ready_out),
        .cpu_irq_out(cpu_irq_out));
    uep_host uep_host_i (.clk_in(clk_in), .reset_in(reset_in), .link(uep_link_if_i),
        .in_token_req_in(in_token_req_in), .out_token_req_in(out_token_req_in),
        .out_len_in(out_len_in), .accept_in(accept_in), .toggle_reset_in(toggle_reset_in),
        .busy_out(busy_out), .result_valid_out(result_valid_out),
        .result_code_out(result_code_out), .result_len_out(result_len_out),
        .result_pid_out(result_pid_out));
    uep_link_checker uep_link_checker_i (.clk_in(clk_in), .reset_in(reset_in),
        .token_valid(uep_link_if_i.token_valid), .token_in(uep_link_if_i.token_in),
        .out_len(uep_link_if_i.out_len), .out_pid(uep_link_if_i.out_pid),
        .done_valid(uep_link_if_i.done_valid), .done_ok(uep_link_if_i.done_ok),
        .hs_valid(uep_link_if_i.hs_valid), .hs_code(uep_link_if_i.hs_code),
        .hs_len(uep_link_if_i.hs_len), .hs_pid(uep_link_if_i.hs_pid));

    function automatic logic [7:0] packet_size_code(input logic [3:0] c);
        logic [7:0] m;
        m = {1'b0, c, 3'h0};
        if (m < 8'h08) m = 8'h08;
        if (m > 8'h10) m = 8'h10;
        return m;
    endfunction : packet_size_code

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic settle();
        repeat (4) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic wr(input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= 8'h30;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 rdv = reg_rdata_out;
    endtask : rd_reg

    // fifo bytes are only counted, so any byte stream will do
    task automatic load(input logic [7:0] len, input logic [31:0] d);
        for (int i = 0; i < len; i++) begin @(posedge clk_in); fifo_wr_in <= 1'b1; end
        @(posedge clk_in);
        fifo_wr_in <= 1'b0;
        wr(d);
        settle();
    endtask : load

    // both ends must drop their toggles together or pids disagree
    task automatic tog_clear(input logic [31:0] d);
        wr(d);
        toggle_reset_in <= 1'b1;
        @(posedge clk_in);
        toggle_reset_in <= 1'b0;
    endtask : tog_clear

    task automatic tok(input logic is_in, input logic [7:0] len);
        int k;
        k = 0;
        @(posedge clk_in);
        in_token_req_in <= is_in;
        out_token_req_in <= !is_in;
        out_len_in <= len;
        @(posedge clk_in);
        in_token_req_in <= 1'b0;
        out_token_req_in <= 1'b0;
        #1 check("busy", busy_out, 1);
        while (result_valid_out !== 1'b1 && k < 20) begin @(posedge clk_in); #1; k++; end
        check("result wait", k < 20, 1);
        settle();
    endtask : tok

    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_reg(8'h30); check("csr reset", rdv, 32'h0000_2001);
        rd_reg(8'h34); check("unmapped", rdv, 32'h0);
        tok(1'b1, 8'h00); check("idle in", result_code_out, UEP_HS_NAK);
        in_tog = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            n = 8'h01 + 8'($unsigned($random(seed)) % 16);
            load(n, 32'h0100_2001);
            check("ready", in_packet_ready_out, 1);
            check("block", fifo_wr_block_out, 1);
            rd_reg(8'h30); check("occ one", rdv[25:24], 2'h2);
            // a refused packet must stay loaded and keep its pid for the retry
            if (i == 0)
            begin
                @(posedge clk_in);
                accept_in <= 1'b0;
                tok(1'b1, 8'h00);
                check("kept ready", in_packet_ready_out, 1);
                check("retry pid", result_pid_out, in_tog);
                @(posedge clk_in);
                accept_in <= 1'b1;
            end
            irq0 = irq_total;
            tok(1'b1, 8'h00);
            check("data", result_code_out, UEP_HS_DATA);
            check("len", result_len_out, n);
            check("in pid", result_pid_out, in_tog);
            check("ready off", in_packet_ready_out, 0);
            check("irq", irq_total, irq0 + 1);
            in_tog = !in_tog;
            if (i == 1) begin tog_clear(32'h4000_2001); in_tog = 1'b0; end
        end
        load(8'h14, 32'h0100_2001);
        rd_reg(8'h30); check("occ big", rdv[25:24], 2'h3);
        irq0 = irq_total;
        wr(32'h0800_2001); settle();
        check("flush ready", in_packet_ready_out, 0);
        check("flush irq", irq_total, irq0 + 1);
        rd_reg(8'h30); check("flush bit", rdv[27], 0);
        load(8'h04, 32'h0100_2001);
        load(8'h05, 32'h0100_2001);
        rd_reg(8'h30); check("occ two", rdv[25:24], 2'h3);
        wr(32'h0800_2001); settle();
        check("two flush", in_packet_ready_out, 1);
        tok(1'b1, 8'h00); check("second len", result_len_out, 0);
        in_tog = !in_tog;
        // flush lands while the oldest packet is on the wire: it must take the second
        load(8'h06, 32'h0100_2001);
        wr(32'h0100_2001);
        fork
            tok(1'b1, 8'h00);
            begin
                repeat (2) @(posedge clk_in);
                wr(32'h0800_2001);
            end
        join
        check("busy flush len", result_len_out, 8'h06);
        check("busy flush ready", in_packet_ready_out, 0);
        load(8'h03, 32'h0100_2001);
        wr(32'h1000_2001);
        tok(1'b1, 8'h00); check("stall", result_code_out, UEP_HS_STALL);
        check("stall ready", in_packet_ready_out, 0);
        rd_reg(8'h30); check("sent stall", rdv[29:28], 2'h3);
        rd_reg(8'h30); check("sent clear", rdv[29], 0);
        load(8'h00, 32'h1100_2001); check("ready held", in_packet_ready_out, 0);
        wr(32'h0000_2001);
        tok(1'b1, 8'h00); check("unstall", result_code_out, UEP_HS_NAK);
        wr(32'h0000_6001);
        tok(1'b1, 8'h00); check("zlp", result_code_out, UEP_HS_ZLP);
        rd_reg(8'h30); check("underrun", rdv[26], 1);
        load(8'h02, 32'h0100_6001); check("dropped", in_packet_ready_out, 0);
        load(8'h02, 32'h0100_6001); check("kept", in_packet_ready_out, 1);
        wr(32'h0800_6001); settle();
        wr(32'h0000_0002);
        tok(1'b1, 8'h00); check("in when out", result_code_out, UEP_HS_NAK);
        tog_clear(32'h0080_0002); out_tog = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            wr({28'h0, 4'(c)});
            for (int k = 0; k < 3; k++)
            begin
                n = (k == 0) ? packet_size_code(4'(c)) : (k == 1) ? packet_size_code(4'(c)) + 8'h01
                    : 8'($unsigned($random(seed)) % 21);
                stl = n > packet_size_code(4'(c));
                tok(1'b0, n);
                check("out code", result_code_out, stl ? UEP_HS_STALL : UEP_HS_ACK);
                check("out pid", result_pid_out, out_tog);
                rd_reg(8'h30); check("out stall flag", rdv[22], stl);
                if (!stl) out_tog = !out_tog;
            end
        end
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
